//--- inc/cif_map.vh
// offsets, field positions, reset values and timing counts of the first interrupt block
`ifndef CIF_MAP_VH
`define CIF_MAP_VH

// register offsets
`define CIF_DAC_STICKY_OFS      7'h2c
`define CIF_ADC_STICKY_OFS      7'h2d
`define CIF_DAC_LIVE_OFS        7'h2e
`define CIF_ADC_LIVE_OFS        7'h2f
`define CIF_CTRL_OFS            7'h30
`define CIF_SAR_CTRL_OFS        7'h32

// adc flag fields
`define CIF_ADC_AGC_NOISE_BIT   6
`define CIF_ADC_PORT_STD_BIT    4
`define CIF_ADC_PORT_AUX_BIT    3
`define CIF_ADC_DC_AVAIL_BIT    2

// dac flag fields
`define CIF_DAC_SHORT_L_BIT     7
`define CIF_DAC_SHORT_R_BIT     6
`define CIF_DAC_BUTTON_BIT      5
`define CIF_DAC_HEADSET_BIT     4
`define CIF_DAC_DRC_L_BIT       3
`define CIF_DAC_DRC_R_BIT       2
`define CIF_DAC_PORT_STD_BIT    1
`define CIF_DAC_PORT_AUX_BIT    0

// control fields
`define CIF_CTL_HEADSET_BIT     7
`define CIF_CTL_BUTTON_BIT      6
`define CIF_CTL_DRC_BIT         5
`define CIF_CTL_AGC_BIT         4
`define CIF_CTL_SHORT_BIT       3
`define CIF_CTL_ENGINE_BIT      2
`define CIF_CTL_DC_BIT          1
`define CIF_CTL_REPEAT_BIT      0

// reset values and bits that may be written in the adc flag registers
`define CIF_CTRL_RESET          8'h00
`define CIF_ADC_RW_MASK         8'ha3

// timing: pulse width and repeat period in microseconds, clock in kHz
`define CIF_CLK_KHZ             250000
`define CIF_PULSE_US            2000
`define CIF_PERIOD_US           4000
// the same figures in clock cycles, sized to the 20-bit timer parameters
`define CIF_PULSE_CYC           20'h7a120
`define CIF_PERIOD_CYC          20'hf4240

`endif

//--- core/cif_pulse_gen.v
// pulse timer for the first interrupt output: single or repeating pulses
`timescale 1ns/1ps
`default_nettype none
module cif_pulse_gen #(
	parameter        CNT_W     = 20,
	parameter [19:0] PULSE_CYC = 20'd500000,
	parameter [19:0] PERIOD_CYC = 20'd1000000
) (
	input  wire       clk_in,
	input  wire       sys_rst_in,
	input  wire       trigger_in,
	input  wire       repeat_in,
	input  wire       stop_in,
	output wire       pulse_out,
	output wire       busy_out
);

	localparam [2:0] ST_IDLE = 3'b001;
	localparam [2:0] ST_HIGH = 3'b010;
	localparam [2:0] ST_LOW  = 3'b100;

	// last count of the high phase and of the period, kept at counter width
	localparam [CNT_W-1:0] CNT_ONE     = {{(CNT_W-1){1'b0}}, 1'b1};
	localparam [CNT_W-1:0] PULSE_LAST  = PULSE_CYC[CNT_W-1:0] - CNT_ONE;
	localparam [CNT_W-1:0] PERIOD_LAST = PERIOD_CYC[CNT_W-1:0] - CNT_ONE;

	reg [2:0]       state_reg;
	reg [2:0]       state_next;
	reg [CNT_W-1:0] cnt_reg;
	reg [CNT_W-1:0] cnt_next;
	reg             pend_reg;
	reg             pend_next;
	reg             out_reg;

	// pend remembers a repeat request until a host read raises stop_in
	always @* begin
		state_next = state_reg;
		cnt_next   = cnt_reg + CNT_ONE;
		pend_next  = pend_reg;
		if (stop_in)
			pend_next = 1'b0;
		case (state_reg)
			ST_IDLE: begin
				cnt_next = {CNT_W{1'b0}};
				if (trigger_in) begin
					state_next = ST_HIGH;
					pend_next  = repeat_in;
				end
			end
			ST_HIGH: begin
				if (cnt_reg == PULSE_LAST)
					state_next = ST_LOW;
			end
			ST_LOW: begin
				// in repeat mode a new event during the gap starts the next pulse on the period
				if (trigger_in && repeat_in)
					pend_next = 1'b1;
				if (cnt_reg == PERIOD_LAST) begin
					cnt_next   = {CNT_W{1'b0}};
					state_next = (pend_next && repeat_in) ? ST_HIGH : ST_IDLE;
				end else if (!repeat_in && !pend_reg) begin
					state_next = ST_IDLE;
				end
			end
			default: begin
				state_next = ST_IDLE;
				cnt_next   = {CNT_W{1'b0}};
				pend_next  = 1'b0;
			end
		endcase
	end

	// state registers; output taken from a flop
	always @(posedge clk_in) begin
		if (sys_rst_in) begin
			state_reg <= ST_IDLE;
			cnt_reg   <= {CNT_W{1'b0}};
			pend_reg  <= 1'b0;
			out_reg   <= 1'b0;
		end else begin
			state_reg <= state_next;
			cnt_reg   <= cnt_next;
			pend_reg  <= pend_next;
			out_reg   <= (state_next == ST_HIGH);
		end
	end

	assign pulse_out = out_reg;
	assign busy_out  = (state_reg != ST_IDLE);

endmodule
`default_nettype wire

//--- core/cif_first_interrupt_output_ctrl.v
// interrupt flag registers and first interrupt output of the codec
`timescale 1ns/1ps
`include "cif_map.vh"
`default_nettype none

// Behaviour
// - adc sticky d6 latches when adc power falls below agc noise threshold.
// - sticky bits read-only, cleared by reading; dac bits and adc d6 set again only on recurrence, adc d4/d3 while the port output stays high.
// - adc sticky d4/d3 latch standard/auxiliary engine port outputs.
// - d2 of both adc registers shows dc measurement available; resets 0.
// - dac live d7/d6 show left/right driver short circuit.
// - dac live d5 button pressed, d4 headset inserted.
// - dac live d3/d2 show left/right power above drc threshold.
// - dac live d1/d0 reflect dac engine standard/auxiliary port outputs.
// - adc live d6 shows mono adc power below agc noise threshold.
// - adc live d4/d3 reflect adc engine ports without latching.
// - control d7..d3 enable headset, button, drc, agc, short sources; reset 0.
// - control d2 enables engine interrupt, d1 dc measurement available.
// - control d0 low gives one 2 ms high pulse per event.
// - control d0 high repeats 2 ms pulses every 4 ms until flags read.
// - the reads that stop repeating include the sticky dac flag register.
module cif_first_interrupt_output_ctrl #(
	parameter        CNT_W      = 20,
	parameter [19:0] PULSE_CYC  = `CIF_PULSE_CYC,
	parameter [19:0] PERIOD_CYC = `CIF_PERIOD_CYC
) (
	input  wire       clk_in,
	input  wire       sys_rst_in,
	input  wire [6:0] reg_addr_in,
	input  wire       reg_wr_in,
	input  wire       reg_rd_in,
	input  wire [7:0] reg_wdata_in,
	output wire [7:0] reg_rdata_out,
	input  wire       short_left_in,
	input  wire       short_right_in,
	input  wire       button_in,
	input  wire       headset_in,
	input  wire       drc_left_in,
	input  wire       drc_right_in,
	input  wire       dac_port_std_in,
	input  wire       dac_port_aux_in,
	input  wire       adc_agc_noise_in,
	input  wire       adc_port_std_in,
	input  wire       adc_port_aux_in,
	input  wire       dc_avail_in,
	output wire [7:0] dac_sticky_out,
	output wire       first_interrupt_output
);

	// the source levels come from analog detectors: two flops each
	reg [11:0] sync1_reg;
	reg [11:0] sync2_reg;
	reg [11:0] prev_reg;
	reg [7:0]  adc_sticky_reg;
	reg [7:0]  adc_sticky_next;
	reg [7:0]  dac_sticky_reg;
	reg [7:0]  dac_sticky_next;
	reg [7:0]  adc_rsv_reg;
	reg [7:0]  ctrl_reg;
	reg [7:0]  rdata_reg;
	reg [7:0]  rdata_next;

	wire [11:0] raw_src;
	wire [11:0] rise;
	wire [7:0]  dac_live;
	wire [7:0]  adc_live;
	wire        rd_dac_sticky;
	wire        rd_adc_sticky;
	wire        rd_sar;
	wire        trig;
	wire        stop;

	assign raw_src = {short_left_in, short_right_in, button_in, headset_in,
		drc_left_in, drc_right_in, dac_port_std_in, dac_port_aux_in,
		adc_agc_noise_in, adc_port_std_in, adc_port_aux_in, dc_avail_in};

	// synchroniser and edge history; edge logic reads only the second stage
	always @(posedge clk_in) begin
		if (sys_rst_in) begin
			sync1_reg <= 12'h000;
			sync2_reg <= 12'h000;
			prev_reg  <= 12'h000;
		end else begin
			sync1_reg <= raw_src;
			sync2_reg <= sync1_reg;
			prev_reg  <= sync2_reg;
		end
	end

	assign rise = sync2_reg & ~prev_reg;

	// live status views
	assign dac_live = sync2_reg[11:4];
	assign adc_live = {adc_rsv_reg[7], sync2_reg[3], adc_rsv_reg[5], sync2_reg[2],
		sync2_reg[1], sync2_reg[0], adc_rsv_reg[1:0]};

	assign rd_dac_sticky = reg_rd_in && (reg_addr_in == `CIF_DAC_STICKY_OFS);
	assign rd_adc_sticky = reg_rd_in && (reg_addr_in == `CIF_ADC_STICKY_OFS);
	assign rd_sar        = reg_rd_in && (reg_addr_in == `CIF_SAR_CTRL_OFS);

	// sticky flags: a read clears, but a new event in the same cycle wins
	always @* begin
		adc_sticky_next = adc_sticky_reg;
		dac_sticky_next = dac_sticky_reg;
		if (rd_adc_sticky)
			adc_sticky_next = 8'h00;
		if (rd_dac_sticky)
			dac_sticky_next = 8'h00;
		adc_sticky_next[`CIF_ADC_AGC_NOISE_BIT] =
			adc_sticky_next[`CIF_ADC_AGC_NOISE_BIT] | rise[3];
		adc_sticky_next[`CIF_ADC_PORT_STD_BIT] =
			adc_sticky_next[`CIF_ADC_PORT_STD_BIT] | sync2_reg[2];
		adc_sticky_next[`CIF_ADC_PORT_AUX_BIT] =
			adc_sticky_next[`CIF_ADC_PORT_AUX_BIT] | sync2_reg[1];
		// headset d4 latches on either insertion or removal
		dac_sticky_next = dac_sticky_next | (rise[11:4] & 8'hef) |
			{3'b000, (sync2_reg[8] ^ prev_reg[8]), 4'h0};
	end

	// sticky and control registers
	always @(posedge clk_in) begin
		if (sys_rst_in) begin
			adc_sticky_reg <= 8'h00;
			dac_sticky_reg <= 8'h00;
			adc_rsv_reg    <= 8'h00;
			ctrl_reg       <= `CIF_CTRL_RESET;
		end else begin
			adc_sticky_reg <= adc_sticky_next;
			dac_sticky_reg <= dac_sticky_next;
			if (reg_wr_in && (reg_addr_in == `CIF_CTRL_OFS))
				ctrl_reg <= reg_wdata_in;
			// host is expected to write zeros here; stored so they read back
			if (reg_wr_in && ((reg_addr_in == `CIF_ADC_STICKY_OFS) ||
					(reg_addr_in == `CIF_ADC_LIVE_OFS)))
				adc_rsv_reg <= reg_wdata_in & `CIF_ADC_RW_MASK;
		end
	end

	// read mux, registered so data outputs come from flops
	always @* begin
		case (reg_addr_in)
			`CIF_DAC_STICKY_OFS: rdata_next = dac_sticky_reg;
			`CIF_ADC_STICKY_OFS: rdata_next = {adc_rsv_reg[7],
				adc_sticky_reg[6], adc_rsv_reg[5], adc_sticky_reg[4:3],
				sync2_reg[0], adc_rsv_reg[1:0]};
			`CIF_DAC_LIVE_OFS:   rdata_next = dac_live;
			`CIF_ADC_LIVE_OFS:   rdata_next = adc_live;
			`CIF_CTRL_OFS:       rdata_next = ctrl_reg;
			default:             rdata_next = 8'h00;
		endcase
	end

	always @(posedge clk_in) begin
		if (sys_rst_in)
			rdata_reg <= 8'h00;
		else if (reg_rd_in)
			rdata_reg <= rdata_next;
	end

	// enabled source events; disabled sources never start a pulse
	assign trig =
		(ctrl_reg[`CIF_CTL_HEADSET_BIT] & (sync2_reg[8] ^ prev_reg[8])) |
		(ctrl_reg[`CIF_CTL_BUTTON_BIT]  & rise[9]) |
		(ctrl_reg[`CIF_CTL_DRC_BIT]     & (rise[7] | rise[6])) |
		(ctrl_reg[`CIF_CTL_AGC_BIT]     & rise[3]) |
		(ctrl_reg[`CIF_CTL_SHORT_BIT]   & (rise[11] | rise[10])) |
		(ctrl_reg[`CIF_CTL_ENGINE_BIT]  & (rise[5] | rise[4] | rise[2] | rise[1])) |
		(ctrl_reg[`CIF_CTL_DC_BIT]      & rise[0]);

	// a read of either sticky flag register or of the sar control register ends repeated pulsing
	assign stop = rd_dac_sticky | rd_adc_sticky | rd_sar;

	cif_pulse_gen #(
		.CNT_W      (CNT_W),
		.PULSE_CYC  (PULSE_CYC),
		.PERIOD_CYC (PERIOD_CYC)
	) u_pulse (
		.clk_in     (clk_in),
		.sys_rst_in (sys_rst_in),
		.trigger_in (trig),
		.repeat_in  (ctrl_reg[`CIF_CTL_REPEAT_BIT]),
		.stop_in    (stop),
		.pulse_out  (first_interrupt_output),
		.busy_out   ()
	);

	assign reg_rdata_out  = rdata_reg;
	assign dac_sticky_out = dac_sticky_reg;

endmodule
`default_nettype wire

//--- testbench/cif_first_interrupt_output_asserts.sv
// port assertions for the first interrupt block
`timescale 1ns/1ps
`default_nettype none
module cif_first_interrupt_output_asserts #(
	parameter [19:0] PULSE_CYC = 20'd20
) (
	input wire logic       clk_in,
	input wire logic       sys_rst_in,
	input wire logic [6:0] reg_addr_in,
	input wire logic       reg_wr_in,
	input wire logic       reg_rd_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic [7:0] reg_rdata_out,
	input wire logic [7:0] dac_sticky_out,
	input wire logic       first_interrupt_output
);
	logic [7:0]  ctl_q;
	logic [19:0] hi_cnt;
	default clocking dcb @(posedge clk_in); endclocking
	default disable iff (sys_rst_in);
	// control shadow and length of the current high run of the pin
	always @(posedge clk_in) begin
		if (sys_rst_in) begin
			ctl_q <= 8'h00;
			hi_cnt <= 20'h0;
		end else begin
			if (reg_wr_in && reg_addr_in == 7'h30)
				ctl_q <= reg_wdata_in;
			hi_cnt <= first_interrupt_output ? hi_cnt + 20'h1 : 20'h0;
		end
	end
	a_ctrl_read_back: assert property (reg_rd_in && reg_addr_in == 7'h30 |=>
		reg_rdata_out == $past(ctl_q)) else $error("control read back differs");
	a_unmapped_zero: assert property (reg_rd_in && reg_addr_in < 7'h2c |=>
		reg_rdata_out == 8'h00) else $error("unmapped read not zero");
	a_reset_quiet: assert property ($fell(sys_rst_in) |-> !first_interrupt_output &&
		reg_rdata_out == 8'h00 && dac_sticky_out == 8'h00) else $error("outputs not idle");
	a_rdata_holds: assert property (!reg_rd_in |=> $stable(reg_rdata_out))
		else $error("read data moved without a read");
	a_sticky_readout: assert property (reg_rd_in && reg_addr_in == 7'h2c |=>
		reg_rdata_out == $past(dac_sticky_out)) else $error("sticky read lost value");
	a_pulse_width: assert property ($fell(first_interrupt_output) |-> hi_cnt == PULSE_CYC)
		else $error("pulse width wrong");
	a_pulse_bound: assert property (hi_cnt <= PULSE_CYC) else $error("pulse too long");
	a_enable_gate: assert property ($rose(first_interrupt_output) && !$past(ctl_q[0]) |->
		$past(ctl_q[7:1]) != 7'h00) else $error("pulse with all sources disabled");
	c_pulse: cover property ($rose(first_interrupt_output));
	c_repeat: cover property ($fell(first_interrupt_output) && ctl_q[0]);
	c_stop_read: cover property (reg_rd_in && reg_addr_in == 7'h2c);
endmodule
bind cif_first_interrupt_output_ctrl cif_first_interrupt_output_asserts #(.PULSE_CYC(PULSE_CYC)) u_cif_first_interrupt_output_asserts (.clk_in,
	.sys_rst_in, .reg_addr_in, .reg_wr_in, .reg_rd_in, .reg_wdata_in, .reg_rdata_out,
	.dac_sticky_out, .first_interrupt_output);
`default_nettype wire

//--- testbench/cif_host_mon.sv
// host model: counts interrupt pulses, times their width and period
`timescale 1ns/1ps
`default_nettype none
module cif_host_mon (
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	input  wire logic        irq_in,
	output var  logic [7:0]  n_pulse_out,
	output var  logic [19:0] width_out,
	output var  logic [19:0] period_out
);
	logic        irq_q;
	logic [19:0] hi_cnt;
	logic [19:0] per_cnt;
	// sampled on the host clock; a pulse under one cycle would go unseen
	always @(posedge clk_in) begin
		irq_q <= irq_in & ~rst_in;
		per_cnt <= (irq_in && !irq_q) ? 20'h1 : per_cnt + 20'h1;
		hi_cnt <= irq_in ? hi_cnt + 20'h1 : 20'h0;
		if (rst_in) begin
			n_pulse_out <= 8'h00;
			width_out <= 20'h0;
			period_out <= 20'h0;
		end else if (irq_in && !irq_q) begin
			n_pulse_out <= n_pulse_out + 8'h01;
			period_out <= per_cnt;
		end else if (!irq_in && irq_q)
			width_out <= hi_cnt;
	end
endmodule
`default_nettype wire

//--- testbench/cif_first_interrupt_output_ctrl_test.sv
// self-checking bench for the first interrupt block
`timescale 1ns/1ps
`default_nettype none
module cif_first_interrupt_output_ctrl_test;
	logic        clk_in = 1'b0;
	logic        sys_rst_in = 1'b1;
	logic [6:0]  addr = 7'h00;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic        rd_q = 1'b0;
	logic [7:0]  wdata = 8'h00;
	logic [7:0]  dac = 8'h00;
	logic [3:0]  adc = 4'h0;
	logic [16:0] lfsr = 17'h17692; // seed 95890
	logic [15:0] note;
	logic [15:0] expq [$];
	logic [7:0]  n0;
	wire  [7:0]  rdata;
	wire  [7:0]  n_pulse;
	wire  [19:0] width;
	wire  [19:0] period;
	wire         irq;
	int          miscompares = 0;
	int          n_compared = 0;
	int          cycles = 0;
	always #2 clk_in = ~clk_in;
	// short counts keep the run brief; expectations use the same figures
	cif_first_interrupt_output_ctrl #(.PULSE_CYC(20'd20), .PERIOD_CYC(20'd40)) u_cif_first_interrupt_output_ctrl (
		.clk_in(clk_in), .sys_rst_in(sys_rst_in), .reg_addr_in(addr), .reg_wr_in(wr),
		.reg_rd_in(rd), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
		.short_left_in(dac[7]), .short_right_in(dac[6]), .button_in(dac[5]),
		.headset_in(dac[4]), .drc_left_in(dac[3]), .drc_right_in(dac[2]),
		.dac_port_std_in(dac[1]), .dac_port_aux_in(dac[0]), .adc_agc_noise_in(adc[3]),
		.adc_port_std_in(adc[2]), .adc_port_aux_in(adc[1]), .dc_avail_in(adc[0]),
		.dac_sticky_out(), .first_interrupt_output(irq));
	cif_host_mon u_cif_host_mon (.clk_in(clk_in), .rst_in(sys_rst_in), .irq_in(irq),
		.n_pulse_out(n_pulse), .width_out(width), .period_out(period));
	function automatic logic [16:0] lfsr_next(input logic [16:0] s);
		return {s[15:0], s[16] ^ s[13]};
	endfunction
	task automatic step(input int n);
		repeat (n) @(posedge clk_in);
	endtask
	task automatic src(input logic [7:0] d, input logic [3:0] a);
		dac <= d;
		adc <= a;
	endtask
	// the extra edge keeps back-to-back strobes from colliding
	task automatic wr_reg(input logic [6:0] a, input logic [7:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		step(1);
		wr <= 1'b0;
		step(1);
	endtask
	task automatic rd_reg(input logic [6:0] a, input logic [7:0] e, input logic [7:0] m);
		expq.push_back({m, e});
		addr <= a;
		rd <= 1'b1;
		step(1);
		rd <= 1'b0;
		step(1);
	endtask
	task automatic chk(input string what, input logic [19:0] e, input logic [19:0] got);
		n_compared++;
		if (got !== e) begin
			miscompares++;
			$display("CHECK FAILED %s expected %0d seen %0d", what, e, got);
		end
	endtask
	task automatic finish_test;
		if (miscompares == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// read answers arrive the cycle after the strobe; match the oldest note
	always @(posedge clk_in) begin
		rd_q <= rd;
		cycles <= cycles + 1;
		if (rd_q) begin
			note = expq.pop_front();
			n_compared++;
			if ((rdata & note[15:8]) !== note[7:0]) begin
				miscompares++;
				$display("CHECK FAILED reg_rdata_out expected %h seen %h", note[7:0],
					rdata & note[15:8]);
			end
		end
		if (cycles == 2000) begin
			miscompares++;
			finish_test();
		end
	end
	initial begin
		step(20);
		sys_rst_in <= 1'b0;
		step(1);
		rd_reg(7'h30, 8'h00, 8'hff);
		rd_reg(7'h10, 8'h00, 8'hff);
		wr_reg(7'h2d, 8'h00);
		wr_reg(7'h2f, 8'h00);
		// random single-pulse control values and live status patterns
		repeat (6) begin
			lfsr = lfsr_next(lfsr);
			src(lfsr[15:8], lfsr[3:0]);
			wr_reg(7'h30, lfsr[7:0] & 8'hfe);
			rd_reg(7'h30, lfsr[7:0] & 8'hfe, 8'hff);
			rd_reg(7'h2e, lfsr[15:8], 8'hff);
			rd_reg(7'h2f, {1'b0, lfsr[3], 1'b0, lfsr[2:0], 2'b00}, 8'hff);
		end
		src(8'h00, 4'h0);
		wr_reg(7'h30, 8'h00);
		step(4);
		// masked reads flush what the random loop latched; then dac sticky must be empty
		rd_reg(7'h2d, 8'h00, 8'h00);
		rd_reg(7'h2c, 8'h00, 8'h00);
		rd_reg(7'h2c, 8'h00, 8'hff);
		// each latched adc flag: set by a brief event, cleared by its read
		for (int i = 1; i < 4; i++) begin
			src(8'h00, 4'h1 << i);
			step(4);
			src(8'h00, 4'h0);
			step(4);
			rd_reg(7'h2d, (i == 3) ? 8'h40 : 8'h04 << i, 8'hff);
			rd_reg(7'h2d, 8'h00, 8'hff);
		end
		wr_reg(7'h30, 8'h10);
		n0 = n_pulse;
		src(8'h00, 4'h8);
		step(60);
		chk("pulse count", n0 + 1, n_pulse);
		chk("pulse width", 20, width);
		src(8'h20, 4'h0);
		step(60);
		chk("pulse count", n0 + 1, n_pulse);
		// dc measurement source alone enabled; its live bit shows in the sticky view
		wr_reg(7'h30, 8'h02);
		src(8'h00, 4'h1);
		step(60);
		chk("pulse count", n0 + 2, n_pulse);
		rd_reg(7'h2d, 8'h44, 8'hff);
		wr_reg(7'h30, 8'h11);
		src(8'h00, 4'h8);
		step(130);
		chk("pulse period", 40, period);
		chk("pulse count", n0 + 6, n_pulse);
		rd_reg(7'h2c, 8'h20, 8'hff);
		rd_reg(7'h2d, 8'h40, 8'hff);
		rd_reg(7'h32, 8'h00, 8'hff);
		step(140);
		chk("pulse count", n0 + 6, n_pulse);
		finish_test();
	end
endmodule
`default_nettype wire
